//--- rtl/vrc_book_if.sv
// carrier between the command engine and the rail code book
interface vrc_book_if;
    logic        upd;
    logic [1:0]  upd_slot;
    logic [7:0]  upd_code;
    logic        max_upd;
    logic [7:0]  max_in;
    logic [1:0]  q_slot;
    logic [7:0]  q_code;
    logic [7:0]  max_code;
    logic        max_valid;
    logic [31:0] all_codes;

    modport book (input upd, upd_slot, upd_code, max_upd, max_in, q_slot,
                  output q_code, max_code, max_valid, all_codes);
    modport user (output upd, upd_slot, upd_code, max_upd, max_in, q_slot,
                  input q_code, max_code, max_valid, all_codes);
endinterface : vrc_book_if

//--- rtl/vrc_command_link.sv
// processor-side command engine for the regulator voltage code bus
// ****************************************
// Overview of operation
// - write the regulator maximum-code register 30h before any voltage request
// - never request a voltage code above the agreed maximum code
// - decay set only for downward targets; regulator lets output fall
// - slow set for ordinary changes, fast set around deep package sleep
// - power-state byte 00h full, 01h light, 02h very light load
// - resend low power state after an upward change if current still low
// - update voltage codes as temperature and load change
// - every packet carries a four-bit rail address 00, 01, 02 or 04
// ****************************************
module vrc_command_link (
    // clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // axi4-lite slave
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_bready,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire logic        s_axi_rready,
    // command link toward the bus framer
    output logic             cmd_valid,
    output logic [2:0]       cmd_op,
    output logic [3:0]       cmd_rail,
    output logic [7:0]       cmd_payload,
    input  wire logic        cmd_ready,
    input  wire logic        ack_valid,
    input  wire logic [1:0]  ack_code,
    // board pin
    input  wire logic        socket_present_low
);

    vrc_book_if bk ();

    vrc_rail_book u_book (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .b       (bk.book)
    );

    // ****************************************
    // axi4-lite slave
    // ****************************************
    logic        aw_have_r, w_have_r;
    logic [7:0]  waddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        do_wr;
    logic        wr_hit;
    logic        rd_hit;
    logic [31:0] rd_word;

    assign do_wr  = aw_have_r && w_have_r && !s_axi_bvalid;
    assign wr_hit = (waddr_r == vrc_pkg::ADDR_CTRL) || (waddr_r == vrc_pkg::ADDR_STAT)
                 || (waddr_r == vrc_pkg::ADDR_CFG);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_have_r     <= 1'b0;
            waddr_r       <= vrc_pkg::ADDR_CTRL;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_have_r     <= 1'b1;
                waddr_r       <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_have_r <= 1'b0;
            end else if (!aw_have_r && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_have_r     <= 1'b0;
            wdata_r      <= vrc_pkg::ZERO_WORD;
            wstrb_r      <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_have_r     <= 1'b1;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
            end else if (do_wr) begin
                w_have_r <= 1'b0;
            end else if (!w_have_r && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= vrc_pkg::RESP_OKAY;
        end else if (ce) begin
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? vrc_pkg::RESP_OKAY : vrc_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= vrc_pkg::ZERO_WORD;
            s_axi_rresp   <= vrc_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rd_hit ? vrc_pkg::RESP_OKAY : vrc_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ****************************************
    // registers and pin synchroniser
    // ****************************************
    vrc_pkg::vrc_state_t state_r;
    logic [1:0]  cfg_r;
    logic [1:0]  last_ack_r;
    logic        fail_r, refuse_r, reissue_r;
    logic [7:0]  ps_cur_r, ps_want_r;
    logic [1:0]  act_slot_r;
    logic        sock_m_r, sock_r;
    logic        go, st_clr;
    logic [7:0]  stat_word;

    assign go     = do_wr && (waddr_r == vrc_pkg::ADDR_CTRL);
    assign st_clr = do_wr && (waddr_r == vrc_pkg::ADDR_STAT) && wstrb_r[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sock_m_r <= 1'b1;
            sock_r   <= 1'b1;
        end else if (ce) begin
            sock_m_r <= socket_present_low;
            sock_r   <= sock_m_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r <= 2'h0;
        end else if (ce && do_wr && (waddr_r == vrc_pkg::ADDR_CFG) && wstrb_r[0]) begin
            cfg_r <= wdata_r[1:0];
        end
    end

    assign stat_word = {reissue_r, bk.max_valid, sock_r, refuse_r, fail_r, last_ack_r,
                        (state_r != vrc_pkg::S_IDLE)};

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = vrc_pkg::ZERO_WORD;
        unique case (s_axi_araddr)
            vrc_pkg::ADDR_CTRL: rd_word = {16'h0000, cmd_payload, 1'b0, cmd_op, cmd_rail};
            vrc_pkg::ADDR_STAT: rd_word[7:0] = stat_word;
            vrc_pkg::ADDR_CFG:  rd_word[1:0] = cfg_r;
            vrc_pkg::ADDR_MAX:  rd_word[7:0] = bk.max_code;
            vrc_pkg::ADDR_RAIL: rd_word = bk.all_codes;
            vrc_pkg::ADDR_PS:   rd_word[7:0] = ps_cur_r;
            default:            rd_hit = 1'b0;
        endcase
    end

    // ****************************************
    // command validation
    // ****************************************
    logic [3:0] c_rail;
    logic [2:0] c_kind, c_op;
    logic [7:0] c_pay;
    logic [2:0] c_slot;
    logic       c_ok, ack_done, ack_good, upward;

    assign c_rail = wdata_r[vrc_pkg::CTRL_RAIL_LSB +: 4];
    assign c_kind = wdata_r[vrc_pkg::CTRL_KIND_LSB +: 3];
    assign c_pay  = wdata_r[vrc_pkg::CTRL_PAY_LSB +: 8];
    assign c_slot = vrc_pkg::rail_slot(c_rail);
    // auto picks slow for ordinary steps, fast around deep sleep
    assign c_op   = (c_kind == vrc_pkg::OP_AUTO)
                  ? (cfg_r[vrc_pkg::CFG_DEEP] ? vrc_pkg::OP_FAST : vrc_pkg::OP_SLOW)
                  : c_kind;

    always_comb begin
        c_ok = 1'b0;
        if (!c_slot[2]) begin
            c_ok = 1'b0;
        end else if (vrc_pkg::is_volt(c_kind)) begin
            c_ok = bk.max_valid && (c_pay <= bk.max_code)
                && ((c_kind != vrc_pkg::OP_DECAY) || (c_pay < bk.q_code));
        end else if (c_kind == vrc_pkg::OP_PSET) begin
            c_ok = (c_pay <= vrc_pkg::PS_VLIGHT);
        end else begin
            c_ok = (c_kind == vrc_pkg::OP_WMAX);
        end
    end

    assign ack_done = ce && (state_r == vrc_pkg::S_WAIT) && ack_valid;
    assign ack_good = ack_done && (ack_code == vrc_pkg::ACK_OK);
    assign upward   = cmd_payload > bk.q_code;

    assign bk.q_slot   = (state_r == vrc_pkg::S_IDLE) ? c_slot[1:0] : act_slot_r;
    assign bk.upd      = ack_good && vrc_pkg::is_volt(cmd_op);
    assign bk.upd_slot = act_slot_r;
    assign bk.upd_code = cmd_payload;
    assign bk.max_upd  = ack_good && (cmd_op == vrc_pkg::OP_WMAX);
    assign bk.max_in   = cmd_payload;

    // ****************************************
    // command engine
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r     <= vrc_pkg::S_IDLE;
            cmd_valid   <= 1'b0;
            cmd_op      <= vrc_pkg::OP_AUTO;
            cmd_rail    <= vrc_pkg::RAIL_CORE;
            cmd_payload <= vrc_pkg::CODE_RESET;
            act_slot_r  <= 2'h0;
        end else if (ce) begin
            unique case (state_r)
                vrc_pkg::S_IDLE: begin
                    if (go && c_ok) begin
                        state_r     <= vrc_pkg::S_SEND;
                        cmd_valid   <= 1'b1;
                        cmd_op      <= c_op;
                        cmd_rail    <= c_rail;
                        cmd_payload <= c_pay;
                        act_slot_r  <= c_slot[1:0];
                    end else if (!go && reissue_r) begin
                        state_r     <= vrc_pkg::S_SEND;
                        cmd_valid   <= 1'b1;
                        cmd_op      <= vrc_pkg::OP_PSET;
                        cmd_payload <= ps_want_r;
                    end
                end
                vrc_pkg::S_SEND: begin
                    if (cmd_ready) begin
                        cmd_valid <= 1'b0;
                        state_r   <= vrc_pkg::S_WAIT;
                    end
                end
                vrc_pkg::S_WAIT: begin
                    if (ack_valid) begin
                        state_r <= vrc_pkg::S_IDLE;
                    end
                end
            endcase
        end
    end

    // power state bookkeeping
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ps_cur_r  <= vrc_pkg::PS_FULL;
            ps_want_r <= vrc_pkg::PS_FULL;
            reissue_r <= 1'b0;
        end else if (ack_good) begin
            if (cmd_op == vrc_pkg::OP_PSET) begin
                ps_cur_r  <= cmd_payload;
                ps_want_r <= cmd_payload;
                reissue_r <= 1'b0;
            end else if (bk.upd && upward && (ps_cur_r != vrc_pkg::PS_FULL)) begin
                ps_cur_r  <= vrc_pkg::PS_FULL;
                reissue_r <= cfg_r[vrc_pkg::CFG_LOWCUR];
            end
        end else if (ack_done && (cmd_op == vrc_pkg::OP_PSET)) begin
            reissue_r <= 1'b0;
        end
    end

    // sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fail_r     <= 1'b0;
            refuse_r   <= 1'b0;
            last_ack_r <= vrc_pkg::ACK_OK;
        end else if (ce) begin
            if (ack_done) begin
                last_ack_r <= ack_code;
            end
            if (ack_done && !ack_good) begin
                fail_r <= 1'b1;
            end else if (st_clr && wdata_r[vrc_pkg::ST_FAIL]) begin
                fail_r <= 1'b0;
            end
            if (go && (!c_ok || (state_r != vrc_pkg::S_IDLE))) begin
                refuse_r <= 1'b1;
            end else if (st_clr && wdata_r[vrc_pkg::ST_REFUSE]) begin
                refuse_r <= 1'b0;
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence seq_auto_go;
        ce && go && c_ok && (state_r == vrc_pkg::S_IDLE) && (c_kind == vrc_pkg::OP_AUTO);
    endsequence
    sequence seq_up_low;
        bk.upd && upward && (ps_cur_r != vrc_pkg::PS_FULL) && cfg_r[vrc_pkg::CFG_LOWCUR];
    endsequence

    AST_MAX_FIRST: assert property (cmd_valid && vrc_pkg::is_volt(cmd_op) |-> bk.max_valid)
        else $error("voltage command before maximum code set");
    AST_MAX_LIMIT: assert property (cmd_valid && vrc_pkg::is_volt(cmd_op)
        |-> cmd_payload <= bk.max_code)
        else $error("voltage code above maximum");
    AST_DECAY_DOWN: assert property (cmd_valid && cmd_op == vrc_pkg::OP_DECAY
        |-> cmd_payload < bk.q_code)
        else $error("decay command not downward");
    AST_PS_CODE: assert property (cmd_valid && cmd_op == vrc_pkg::OP_PSET
        |-> cmd_payload <= vrc_pkg::PS_VLIGHT)
        else $error("illegal power state byte");
    AST_RAIL_ADDR: assert property (cmd_valid |-> vrc_pkg::rail_slot(cmd_rail) > 3'h3)
        else $error("illegal rail address");
    AST_ONE_OUT: assert property (state_r == vrc_pkg::S_WAIT && !ack_valid |=> !cmd_valid)
        else $error("second command before acknowledgement");
    AST_AUTO_PICK: assert property (seq_auto_go |=> cmd_valid
        && (cmd_op == ($past(cfg_r[0]) ? vrc_pkg::OP_FAST : vrc_pkg::OP_SLOW)))
        else $error("auto voltage set picked wrong speed");
    AST_REISSUE: assert property (seq_up_low |=> reissue_r
        ##[1:3] (cmd_valid && cmd_op == vrc_pkg::OP_PSET)
        or (reissue_r && !ce) or (reissue_r && go))
        else $error("low power state not resent");
    AST_FAIL_FLAG: assert property (ack_done && ack_code != vrc_pkg::ACK_OK |=> fail_r)
        else $error("failed acknowledgement not flagged");

endmodule : vrc_command_link

//--- rtl/vrc_pkg.sv
// shared constants, types and helpers of the voltage command link
package vrc_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_CFG  = 8'h08;
    localparam logic [7:0] ADDR_MAX  = 8'h0C;
    localparam logic [7:0] ADDR_RAIL = 8'h10;
    localparam logic [7:0] ADDR_PS   = 8'h14;

    // ctrl fields
    localparam int CTRL_RAIL_LSB = 0;
    localparam int CTRL_KIND_LSB = 4;
    localparam int CTRL_PAY_LSB  = 8;
    // status fields
    localparam int ST_BUSY    = 0;
    localparam int ST_ACK_LSB = 1;
    localparam int ST_FAIL    = 3;
    localparam int ST_REFUSE  = 4;
    localparam int ST_SOCKET  = 5;
    localparam int ST_MAXSET  = 6;
    localparam int ST_REISSUE = 7;
    // config fields
    localparam int CFG_DEEP   = 0;
    localparam int CFG_LOWCUR = 1;

    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ****************************************
    // command encodings
    // ****************************************
    // kind field of ctrl equals the link opcode, except auto
    localparam logic [2:0] OP_AUTO  = 3'h0;
    localparam logic [2:0] OP_FAST  = 3'h1;
    localparam logic [2:0] OP_SLOW  = 3'h2;
    localparam logic [2:0] OP_DECAY = 3'h3;
    localparam logic [2:0] OP_PSET  = 3'h4;
    localparam logic [2:0] OP_WMAX  = 3'h5;

    localparam logic [7:0] MAX_REG_ADDR = 8'h30;

    localparam logic [7:0] PS_FULL   = 8'h00;
    localparam logic [7:0] PS_LIGHT  = 8'h01;
    localparam logic [7:0] PS_VLIGHT = 8'h02;

    localparam logic [1:0] ACK_OK     = 2'h0;
    localparam logic [1:0] ACK_NOSUP  = 2'h1;
    localparam logic [1:0] ACK_REJECT = 2'h3;

    localparam logic [3:0] RAIL_CORE = 4'h0;
    localparam logic [3:0] RAIL_SA   = 4'h1;
    localparam logic [3:0] RAIL_MEM0 = 4'h2;
    localparam logic [3:0] RAIL_MEM1 = 4'h4;
    localparam int         NUM_RAILS = 4;
    localparam logic [7:0] CODE_RESET = 8'h00;

    typedef enum logic [1:0] {S_IDLE, S_SEND, S_WAIT} vrc_state_t;

    // rail address to {valid, slot}
    function automatic logic [2:0] rail_slot(input logic [3:0] a);
        unique case (a)
            RAIL_CORE: rail_slot = 3'h4;
            RAIL_SA:   rail_slot = 3'h5;
            RAIL_MEM0: rail_slot = 3'h6;
            RAIL_MEM1: rail_slot = 3'h7;
            default:   rail_slot = 3'h0;
        endcase
    endfunction : rail_slot

    function automatic logic is_volt(input logic [2:0] k);
        is_volt = (k == OP_AUTO) || (k == OP_FAST) || (k == OP_SLOW) || (k == OP_DECAY);
    endfunction : is_volt

endpackage : vrc_pkg

//--- rtl/vrc_rail_book.sv
// last acknowledged voltage code of each rail and the agreed maximum code
module vrc_rail_book (
    // clock and control
    input  wire logic   aclk,
    input  wire logic   aresetn,
    input  wire logic   ce,
    // engine side
    vrc_book_if.book    b
);

    // ****************************************
    // storage
    // ****************************************
    logic [7:0] codes_r [vrc_pkg::NUM_RAILS];
    logic [7:0] max_r;
    logic       max_valid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < vrc_pkg::NUM_RAILS; i++) begin
                codes_r[i] <= vrc_pkg::CODE_RESET;
            end
        end else if (ce && b.upd) begin
            codes_r[b.upd_slot] <= b.upd_code;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            max_r       <= vrc_pkg::CODE_RESET;
            max_valid_r <= 1'b0;
        end else if (ce && b.max_upd) begin
            max_r       <= b.max_in;
            max_valid_r <= 1'b1;
        end
    end

    assign b.q_code    = codes_r[b.q_slot];
    assign b.max_code  = max_r;
    assign b.max_valid = max_valid_r;
    assign b.all_codes = {codes_r[3], codes_r[2], codes_r[1], codes_r[0]};

endmodule : vrc_rail_book

//--- verification/vrc_command_link_tb.sv
// self-checking bench of the voltage command link
module vrc_command_link_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, ce, socket_present_low, slow;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, cmd_valid, cmd_ready, ack_valid;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, cmd_payload, l_pay;
    logic [31:0] s_axi_wdata, s_axi_rdata, st;
    logic [3:0]  s_axi_wstrb, cmd_rail, l_rail;
    logic [1:0]  s_axi_bresp, s_axi_rresp, ack_code, rsp;
    logic [2:0]  cmd_op, l_op;
    int          num_errors = 0, check_count = 0, n_cmd = 0, cyc = 0, n0;

    vrc_command_link dut (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bresp,
        .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rready, .cmd_valid, .cmd_op, .cmd_rail,
        .cmd_payload, .cmd_ready, .ack_valid, .ack_code, .socket_present_low);
    vrc_reg_model model (.aclk, .aresetn, .cmd_valid, .cmd_op, .cmd_rail, .cmd_payload,
        .cmd_ready, .ack_valid, .ack_code, .slow, .socket_empty(socket_present_low));

    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read

    // polls until idle and no resend pending
    task automatic launch(input logic [3:0] r, input logic [2:0] k, input logic [7:0] p);
        axi_write(vrc_pkg::ADDR_CTRL, {16'h0000, p, 1'b0, k, r}, rsp);
        do axi_read(vrc_pkg::ADDR_STAT, st, rsp); while ((st & 32'h0000_0081) != 32'h0000_0000);
    endtask : launch

    task automatic step(input logic [3:0] r, input logic [2:0] k, input logic [7:0] p,
                        input int sent, input logic [2:0] op, input logic [1:0] a);
        axi_write(vrc_pkg::ADDR_STAT, 32'h0000_0018, rsp);
        n0 = n_cmd;
        launch(r, k, p);
        check(n_cmd, n0 + sent);
        if (sent > 0) begin
            check({l_op, l_rail, l_pay}, {op, r, p});
            check(st[4:1], {1'b0, a != 2'h0, a});
        end else check(st[4], 1'b1);
    endtask : step

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cmd_valid && cmd_ready) begin
            n_cmd <= n_cmd + 1;
            l_op <= cmd_op;
            l_rail <= cmd_rail;
            l_pay <= cmd_payload;
        end
        if (cyc == 20000) begin
            num_errors++;
            print_verdict();
        end
    end

    // ****************************************
    // sequence
    // ****************************************
    initial begin
        {aresetn, socket_present_low, slow, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        ce = 1'b1;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(vrc_pkg::ADDR_STAT, st, rsp);
        check(st[6], 1'b0);
        axi_read(8'h20, st, rsp);
        check(rsp, vrc_pkg::RESP_SLVERR);
        axi_write(vrc_pkg::ADDR_MAX, 32'h0000_00FF, rsp);
        check(rsp, vrc_pkg::RESP_SLVERR);
        step(vrc_pkg::RAIL_CORE, vrc_pkg::OP_FAST, 8'h40, 0, 3'h0, 2'h0);
        step(vrc_pkg::RAIL_CORE, vrc_pkg::OP_WMAX, 8'hB0, 1, vrc_pkg::OP_WMAX, 2'h0);
        axi_read(vrc_pkg::ADDR_MAX, st, rsp);
        check(st, 32'h0000_00B0);
        step(vrc_pkg::RAIL_CORE, vrc_pkg::OP_SLOW, 8'hB1, 0, 3'h0, 2'h0);
        step(vrc_pkg::RAIL_CORE, vrc_pkg::OP_SLOW, 8'hB0, 1, vrc_pkg::OP_SLOW, 2'h1);
        $display("test maximum code done");
        slow <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            step(4'(i), vrc_pkg::OP_SLOW, 8'h50 + 8'(i), int'(i inside {0, 1, 2, 4}),
                 vrc_pkg::OP_SLOW, 2'h0);
        end
        slow <= 1'b0;
        axi_read(vrc_pkg::ADDR_RAIL, st, rsp);
        check(st, 32'h5452_5150);
        step(vrc_pkg::RAIL_CORE, vrc_pkg::OP_DECAY, 8'h50, 0, 3'h0, 2'h0);
        step(vrc_pkg::RAIL_CORE, vrc_pkg::OP_DECAY, 8'h48, 1, vrc_pkg::OP_DECAY, 2'h0);
        $display("test rails done");
        for (int i = 0; i < 4; i++) begin
            step(vrc_pkg::RAIL_CORE, vrc_pkg::OP_PSET, 8'(i), int'(i < 3), vrc_pkg::OP_PSET,
                 (i == 2) ? vrc_pkg::ACK_REJECT : vrc_pkg::ACK_OK);
        end
        axi_read(vrc_pkg::ADDR_PS, st, rsp);
        check(st, 32'h0000_0001);
        axi_write(vrc_pkg::ADDR_CFG, 32'h0000_0000, rsp);
        step(vrc_pkg::RAIL_SA, vrc_pkg::OP_AUTO, 8'h60, 1, vrc_pkg::OP_SLOW, 2'h0);
        axi_read(vrc_pkg::ADDR_PS, st, rsp);
        check(st, 32'h0000_0000);
        axi_write(vrc_pkg::ADDR_CFG, 32'h0000_0001, rsp);
        step(vrc_pkg::RAIL_SA, vrc_pkg::OP_AUTO, 8'h58, 1, vrc_pkg::OP_FAST, 2'h0);
        $display("test power states done");
        axi_write(vrc_pkg::ADDR_CFG, 32'h0000_0002, rsp);
        step(vrc_pkg::RAIL_CORE, vrc_pkg::OP_PSET, 8'h01, 1, vrc_pkg::OP_PSET, 2'h0);
        n0 = n_cmd;
        launch(vrc_pkg::RAIL_CORE, vrc_pkg::OP_SLOW, 8'h70);
        check(n_cmd, n0 + 2);
        check({l_op, l_pay}, {vrc_pkg::OP_PSET, vrc_pkg::PS_LIGHT});
        axi_read(vrc_pkg::ADDR_PS, st, rsp);
        check(st, 32'h0000_0001);
        socket_present_low <= 1'b1;
        repeat (4) @(posedge aclk);
        axi_read(vrc_pkg::ADDR_STAT, st, rsp);
        check(st[5], 1'b1);
        step(vrc_pkg::RAIL_MEM0, vrc_pkg::OP_SLOW, 8'h40, 1, vrc_pkg::OP_SLOW, 2'h1);
        socket_present_low <= 1'b0;
        $display("test resend and socket done");
        print_verdict();
    end
endmodule : vrc_command_link_tb

//--- verification/vrc_reg_model.sv
// regulator controller model at the far end of the command link
module vrc_reg_model #(
    parameter logic [7:0] TOP_CODE = 8'hA0,
    parameter logic [7:0] TOP_PS   = 8'h01
) (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // command link
    input  wire logic       cmd_valid,
    input  wire logic [2:0] cmd_op,
    input  wire logic [3:0] cmd_rail,
    input  wire logic [7:0] cmd_payload,
    output logic            cmd_ready,
    output logic            ack_valid,
    output logic [1:0]      ack_code,
    // bench controls
    input  wire logic       slow,
    input  wire logic       socket_empty
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_r;
    logic [1:0] code_r;
    logic [7:0] ps_r;
    logic [7:0] volt_r [16];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_ready <= 1'b0;
            ack_valid <= 1'b0;
            ack_code  <= 2'h0;
            wait_r    <= 4'h0;
            ps_r      <= vrc_pkg::PS_FULL;
            for (int i = 0; i < 16; i++) volt_r[i] <= 8'h00;
        end else begin
            cmd_ready <= cmd_valid && !cmd_ready && wait_r == 4'h0;
            ack_valid <= wait_r == 4'h1;
            // code moves outside the pulse so a stale sample never matches
            ack_code  <= (wait_r == 4'h1) ? code_r : ~ack_code;
            if (wait_r != 4'h0) wait_r <= wait_r - 4'h1;
            if (cmd_valid && cmd_ready) begin
                wait_r <= slow ? 4'hC : 4'h2;
                if (cmd_op == vrc_pkg::OP_PSET) begin
                    code_r <= (cmd_payload > TOP_PS) ? vrc_pkg::ACK_REJECT : vrc_pkg::ACK_OK;
                    if (cmd_payload <= TOP_PS) ps_r <= cmd_payload;
                end else if (cmd_op == vrc_pkg::OP_WMAX) begin
                    code_r <= vrc_pkg::ACK_OK;
                end else if (socket_empty || cmd_payload > TOP_CODE) begin
                    code_r <= vrc_pkg::ACK_NOSUP;
                end else begin
                    code_r <= vrc_pkg::ACK_OK;
                    if (cmd_payload > volt_r[cmd_rail]) ps_r <= vrc_pkg::PS_FULL;
                    volt_r[cmd_rail] <= cmd_payload;
                end
            end
        end
    end
endmodule : vrc_reg_model
